/* File: core/cbt_defines.svh */
// constants for the can bit timing and timestamp timer block
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH
`define CBT_TIMER_W 16
`define CBT_TIMER_MAX 16'hffff
`define CBT_TIMER_RST 16'h0000
`define CBT_SYNC_TQ 4'h1
`define CBT_IPT_TQ 4'h2
`define CBT_SEG_W 4
`define CBT_BRP_W 6
`define CBT_SJW_W 2
`define CBT_OBJ_N 15
`define CBT_OBJ_W 4
`endif

/* File: core/cbt_pkg.sv */
// types for the can bit timing and timestamp timer block
package cbt_pkg;
    typedef enum logic [1:0] {
        CBT_SEG_SYNC = 2'b00,
        CBT_SEG_PROP = 2'b01,
        CBT_SEG_PH1 = 2'b10,
        CBT_SEG_PH2 = 2'b11
    } cbt_seg_t;
    typedef logic [15:0] cbt_stamp_t;
endpackage : cbt_pkg

/* File: core/cbt_rx_sync.sv */
// three-stage synchroniser for the can receive pin
`timescale 1ns/1ps
module cbt_rx_sync (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_pin,
    output logic o_level
);
    logic s1;
    logic s2;
    logic s3;
    // a change counts only once stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            o_level <= 1'b1;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule : cbt_rx_sync

/* File: core/cbt_timer.sv */
// free-running 16-bit can timer with wrap pulse
`timescale 1ns/1ps
`include "cbt_defines.svh"
module cbt_timer (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_enable,
    input wire logic i_tick,
    output cbt_pkg::cbt_stamp_t o_count,
    output logic o_wrap
);
    import cbt_pkg::*;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_count <= `CBT_TIMER_RST;
            o_wrap <= 1'b0;
        end else begin
            o_wrap <= 1'b0;
            if (i_enable && i_tick) begin // R11
                o_count <= o_count + 16'h0001; // R17
                o_wrap <= (o_count == `CBT_TIMER_MAX); // R17
            end
        end
    end
endmodule : cbt_timer

/* File: core/cbt_top.sv */
// can bit segmentation, resynchronisation and timestamp capture
// Contract
// R1 - transmit bit level is driven at the start of the sync segment
// R2 - receivers expect bus edges to fall inside the sync segment
// R3 - a propagation segment follows sync to absorb bus and transceiver delay
// R4 - resync may lengthen phase segment one
// R5 - bus level is sampled at the end of phase segment one
// R6 - resync may shorten phase segment two
// R7 - phase two never longer than phase one, never below processing time; code keeps phase two at two quanta when phase one is shorter
// R8 - processing time starts at the sample point and lasts two quanta
// R9 - a late edge lengthens phase one, moving sample point and bit end
// R10 - a 16-bit timer readable as high and low bytes is the time base
// R11 - the timer counts only after the controller enable bit is set
// R12 - time-triggered mode captures timer at start or end of frame per select bit
// R13 - time-triggered mode sends each frame once, no retransmit after error
// R14 - stamp of the object that sent or received the frame takes the timer
// R15 - receive stamp is taken when the receive-success flag sets
// R16 - transmit stamp is taken when the transmit-success flag sets
// R17 - timer runs freely and wraps from all ones to zero
// R18 - each wrap raises an interrupt request when enabled
// R19 - time-triggered bit enables the mode, clear disables all its features
// R20 - sync is one quantum; order is sync, propagation, phase one, phase two
// R21 - each 16-bit capture stores high and low bytes from one count
`timescale 1ns/1ps
`include "cbt_defines.svh"
module cbt_top #(
    parameter int OBJ_N = `CBT_OBJ_N
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_controller_enable_bit,
    input wire logic i_time_triggered_mode_bit,
    input wire logic i_trigger_capture_edge_select,
    input wire logic i_timer_wrap_irq_enable,
    input wire logic [`CBT_BRP_W-1:0] i_prescale,
    input wire logic [`CBT_SEG_W-1:0] i_prop_tq,
    input wire logic [`CBT_SEG_W-1:0] i_ph1_tq,
    input wire logic [`CBT_SEG_W-1:0] i_ph2_tq,
    input wire logic [`CBT_SJW_W-1:0] i_sjw_tq,
    input wire logic [7:0] i_timer_prescale,
    input wire logic i_rx_pin,
    input wire logic i_tx_bit,
    input wire logic i_tx_active,
    input wire logic i_hard_sync,
    input wire logic i_sof,
    input wire logic i_eof,
    input wire logic i_tx_error,
    input wire logic [`CBT_OBJ_W-1:0] i_obj_index,
    input wire logic i_receive_success_flag,
    input wire logic i_transmit_success_flag,
    input wire logic [`CBT_OBJ_W-1:0] i_stamp_sel,
    output logic o_tx_pin,
    output logic o_sample_strobe,
    output logic o_sample_bit,
    output logic o_bit_start,
    output logic o_ipt_busy,
    output logic o_retransmit_allowed,
    output logic [7:0] o_stamp_timer_high,
    output logic [7:0] o_stamp_timer_low,
    output logic [7:0] o_trigger_capture_high,
    output logic [7:0] o_trigger_capture_low,
    output logic [7:0] o_object_stamp_high,
    output logic [7:0] o_object_stamp_low,
    output logic o_timer_irq
);
    import cbt_pkg::*;

    localparam logic [`CBT_SEG_W:0] SYNC_TQ = {1'b0, `CBT_SYNC_TQ};
    localparam logic [`CBT_SEG_W-1:0] IPT_TQ = `CBT_IPT_TQ;

    cbt_seg_t seg;
    logic [`CBT_BRP_W-1:0] tq_div;
    logic tq_tick;
    logic [`CBT_SEG_W:0] tq_cnt;
    logic [`CBT_SEG_W:0] ph1_len;
    logic [`CBT_SEG_W:0] ph2_len;
    logic [`CBT_SEG_W-1:0] ph2_eff;
    logic [2:0] ipt_cnt;
    logic rx_level;
    logic rx_prev;
    logic rx_fall;
    logic [7:0] tim_div;
    logic tim_tick;
    cbt_stamp_t timer_count;
    logic timer_wrap;
    cbt_stamp_t stamp_mem [OBJ_N];

    cbt_rx_sync u_rx_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_rx_pin),
        .o_level(rx_level)
    );

    // clamp a segment length to at least one quantum
    function automatic logic [`CBT_SEG_W:0] cbt_len(input logic [`CBT_SEG_W-1:0] v);
        cbt_len = (v == '0) ? {{`CBT_SEG_W{1'b0}}, 1'b1} : {1'b0, v};
    endfunction : cbt_len

    // phase two is capped at phase one, then raised to at least processing time
    always_comb begin
        if (i_ph2_tq > i_ph1_tq) begin
            ph2_eff = i_ph1_tq; // R7
        end else begin
            ph2_eff = i_ph2_tq;
        end
        if (ph2_eff < IPT_TQ) begin
            ph2_eff = IPT_TQ; // R7
        end
    end

    // time quantum enable from the prescaler
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !i_controller_enable_bit) begin
            tq_div <= '0;
            tq_tick <= 1'b0;
        end else if (tq_div >= i_prescale) begin
            tq_div <= '0;
            tq_tick <= 1'b1;
        end else begin
            tq_div <= tq_div + 1'b1;
            tq_tick <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_level;
        end
    end
    assign rx_fall = rx_prev && !rx_level;

    // segment sequencer; resync only on recessive-to-dominant edges
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !i_controller_enable_bit) begin
            seg <= CBT_SEG_SYNC;
            tq_cnt <= '0;
            ph1_len <= '0;
            ph2_len <= '0;
        end else if (i_hard_sync && rx_fall) begin
            seg <= CBT_SEG_PROP; // R2
            tq_cnt <= '0;
            // a hard sync skips the sync-to-prop step, so the lengths are loaded here
            ph1_len <= cbt_len(i_ph1_tq);
            ph2_len <= {1'b0, ph2_eff};
        end else begin
            if (rx_fall && !i_tx_active) begin
                if (seg == CBT_SEG_PROP || seg == CBT_SEG_PH1) begin
                    ph1_len <= cbt_len(i_ph1_tq) + {3'b000, i_sjw_tq}; // R4 R9
                end else if (seg == CBT_SEG_PH2) begin
                    if (ph2_len > {3'b000, i_sjw_tq} + {1'b0, IPT_TQ}) begin
                        ph2_len <= ph2_len - {3'b000, i_sjw_tq}; // R6
                    end else begin
                        ph2_len <= {1'b0, IPT_TQ}; // R7 R8
                    end
                end
            end
            if (tq_tick) begin
                tq_cnt <= tq_cnt + 1'b1;
                case (seg)
                    CBT_SEG_SYNC: begin
                        if (tq_cnt + 1'b1 >= SYNC_TQ) begin // R20
                            seg <= CBT_SEG_PROP;
                            tq_cnt <= '0;
                            ph1_len <= cbt_len(i_ph1_tq);
                            ph2_len <= {1'b0, ph2_eff};
                        end
                    end
                    CBT_SEG_PROP: begin
                        if (tq_cnt + 1'b1 >= cbt_len(i_prop_tq)) begin // R3
                            seg <= CBT_SEG_PH1;
                            tq_cnt <= '0;
                        end
                    end
                    CBT_SEG_PH1: begin
                        if (tq_cnt + 1'b1 >= ph1_len) begin
                            seg <= CBT_SEG_PH2;
                            tq_cnt <= '0;
                        end
                    end
                    CBT_SEG_PH2: begin
                        if (tq_cnt + 1'b1 >= ph2_len) begin
                            seg <= CBT_SEG_SYNC;
                            tq_cnt <= '0;
                        end
                    end
                    default: begin
                        seg <= CBT_SEG_SYNC;
                        tq_cnt <= '0;
                    end
                endcase
            end
        end
    end

    // sample point and transmit drive
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_sample_strobe <= 1'b0;
            o_sample_bit <= 1'b1;
            o_bit_start <= 1'b0;
            o_tx_pin <= 1'b1;
        end else begin
            o_sample_strobe <= 1'b0;
            o_bit_start <= 1'b0;
            if (tq_tick && seg == CBT_SEG_PH1 && tq_cnt + 1'b1 >= ph1_len) begin
                o_sample_strobe <= 1'b1; // R5
                o_sample_bit <= rx_level; // R5
            end
            if (tq_tick && seg == CBT_SEG_PH2 && tq_cnt + 1'b1 >= ph2_len) begin
                o_bit_start <= 1'b1;
                o_tx_pin <= i_tx_active ? i_tx_bit : 1'b1; // R1
            end
        end
    end

    // processing window of two quanta after the sample point
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ipt_cnt <= '0;
        end else if (o_sample_strobe) begin
            ipt_cnt <= {1'b0, IPT_TQ[1:0]}; // R8
        end else if (tq_tick && ipt_cnt != '0) begin
            ipt_cnt <= ipt_cnt - 1'b1;
        end
    end
    assign o_ipt_busy = (ipt_cnt != '0);

    // no retry in time-triggered mode
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_retransmit_allowed <= 1'b1;
        end else begin
            o_retransmit_allowed <= !i_time_triggered_mode_bit || !i_tx_error; // R13 R19
        end
    end

    // timer clock divider keeps the count off the bit-rate prescaler
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !i_controller_enable_bit) begin
            tim_div <= '0;
            tim_tick <= 1'b0;
        end else if (tim_div >= i_timer_prescale) begin
            tim_div <= '0;
            tim_tick <= 1'b1;
        end else begin
            tim_div <= tim_div + 1'b1;
            tim_tick <= 1'b0;
        end
    end

    cbt_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_enable(i_controller_enable_bit),
        .i_tick(tim_tick),
        .o_count(timer_count),
        .o_wrap(timer_wrap)
    );

    assign o_stamp_timer_high = timer_count[15:8]; // R10
    assign o_stamp_timer_low = timer_count[7:0]; // R10

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_timer_irq <= 1'b0;
        end else begin
            o_timer_irq <= timer_wrap && i_timer_wrap_irq_enable; // R18
        end
    end

    // trigger capture, both bytes from one sampled count
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_trigger_capture_high <= 8'h00;
            o_trigger_capture_low <= 8'h00;
        end else if (i_time_triggered_mode_bit && // R19
                     (i_trigger_capture_edge_select ? i_eof : i_sof)) begin // R12
            {o_trigger_capture_high, o_trigger_capture_low} <= timer_count; // R21
        end
    end

    // per-object stamps; success flags are one-cycle set pulses
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            for (int k = 0; k < OBJ_N; k++) begin
                stamp_mem[k] <= `CBT_TIMER_RST;
            end
        end else if ((i_receive_success_flag || i_transmit_success_flag) // R15 R16
                     && int'(i_obj_index) < OBJ_N) begin
            stamp_mem[i_obj_index] <= timer_count; // R14 R21
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_object_stamp_high <= 8'h00;
            o_object_stamp_low <= 8'h00;
        end else if (int'(i_stamp_sel) < OBJ_N) begin
            {o_object_stamp_high, o_object_stamp_low} <= stamp_mem[i_stamp_sel];
        end else begin
            o_object_stamp_high <= 8'h00;
            o_object_stamp_low <= 8'h00;
        end
    end
endmodule : cbt_top

/* File: test/cbt_top_asserts.sv */
// concurrent checks on the can timer and stamp ports
`timescale 1ns/1ps
`include "cbt_defines.svh"
module cbt_top_asserts #(
    parameter int OBJ_N = `CBT_OBJ_N
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_controller_enable_bit,
    input wire logic i_time_triggered_mode_bit,
    input wire logic i_trigger_capture_edge_select,
    input wire logic i_timer_wrap_irq_enable,
    input wire logic i_sof,
    input wire logic i_eof,
    input wire logic i_tx_error,
    input wire logic [`CBT_OBJ_W-1:0] i_obj_index,
    input wire logic i_receive_success_flag,
    input wire logic i_transmit_success_flag,
    input wire logic [`CBT_OBJ_W-1:0] i_stamp_sel,
    input wire logic o_tx_pin,
    input wire logic o_sample_strobe,
    input wire logic o_sample_bit,
    input wire logic o_bit_start,
    input wire logic o_ipt_busy,
    input wire logic o_retransmit_allowed,
    input wire logic [7:0] o_stamp_timer_high,
    input wire logic [7:0] o_stamp_timer_low,
    input wire logic [7:0] o_trigger_capture_high,
    input wire logic [7:0] o_trigger_capture_low,
    input wire logic [7:0] o_object_stamp_high,
    input wire logic [7:0] o_object_stamp_low,
    input wire logic o_timer_irq
);
    logic [15:0] cnt;
    logic [15:0] trig;
    logic [15:0] ostamp;
    assign cnt = {o_stamp_timer_high, o_stamp_timer_low};
    assign trig = {o_trigger_capture_high, o_trigger_capture_low};
    assign ostamp = {o_object_stamp_high, o_object_stamp_low};
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    sequence s_wrap;
        i_timer_wrap_irq_enable && cnt == 16'hffff ##1 cnt == 16'h0000;
    endsequence
    sequence s_rx;
        i_receive_success_flag && !i_transmit_success_flag && i_obj_index < OBJ_N
            ##1 i_stamp_sel == $past(i_obj_index);
    endsequence
    sequence s_tx;
        i_transmit_success_flag && !i_receive_success_flag && i_obj_index < OBJ_N
            ##1 i_stamp_sel == $past(i_obj_index);
    endsequence
    AST_TIMER_HOLD: assert property (!i_controller_enable_bit |=> $stable(cnt))
        else $error("timer moved while disabled");
    // a reset may drop the count to zero, so steps right after one are skipped
    AST_TIMER_STEP: assert property (!$stable(cnt) && !$past(i_sys_rst) |-> cnt == 16'($past(cnt) + 16'h0001))
        else $error("timer stepped by other than one");
    AST_WRAP_IRQ: assert property (s_wrap |-> ##[0:2] o_timer_irq)
        else $error("no irq after timer wrap");
    AST_TRIG_CAPTURE: assert property (i_time_triggered_mode_bit
        && (i_trigger_capture_edge_select ? i_eof : i_sof) |=> trig == $past(cnt))
        else $error("trigger capture value wrong");
    AST_TRIG_OFF: assert property (!i_time_triggered_mode_bit |=> $stable(trig))
        else $error("trigger capture moved outside time-triggered mode");
    AST_STAMP_RX: assert property (s_rx |=> ostamp == $past(cnt, 2))
        else $error("receive stamp wrong");
    AST_STAMP_TX: assert property (s_tx |=> ostamp == $past(cnt, 2))
        else $error("transmit stamp wrong");
    AST_NO_RETX: assert property (i_time_triggered_mode_bit && i_tx_error |=> !o_retransmit_allowed)
        else $error("retransmit allowed after error in time-triggered mode");
    AST_TX_AT_BIT_START: assert property (!o_bit_start |-> $stable(o_tx_pin))
        else $error("transmit level changed away from a bit start");
    AST_SAMPLE_AT_POINT: assert property (!o_sample_strobe |-> $stable(o_sample_bit))
        else $error("sampled bit changed away from the sample point");
    AST_IPT_AFTER_SAMPLE: assert property (o_sample_strobe |=> o_ipt_busy)
        else $error("processing time not running after the sample point");
endmodule : cbt_top_asserts
bind cbt_top cbt_top_asserts #(.OBJ_N(OBJ_N)) chk_u (.*);

/* File: test/cbt_peer.sv */
// far-side can node on a wired-and bus
`timescale 1ns/1ps
module cbt_peer (
    input wire logic i_tx_pin,
    input wire logic i_drive_low,
    output logic o_bus
);
    // recessive is the pulled-up idle level, so a released bus reads 1
    assign o_bus = i_tx_pin & ~i_drive_low;
endmodule : cbt_peer

/* File: test/tb_top.sv */
// self-checking bench for the can timer, stamps and bit timing
`timescale 1ns/1ps
`include "cbt_defines.svh"
module tb_top;
    import cbt_pkg::*;
    logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_controller_enable_bit = 1'b0;
    logic i_time_triggered_mode_bit = 1'b0, i_trigger_capture_edge_select = 1'b0;
    logic i_timer_wrap_irq_enable = 1'b0, i_tx_bit = 1'b1, i_tx_active = 1'b0;
    logic i_hard_sync = 1'b0, i_sof = 1'b0, i_eof = 1'b0, i_tx_error = 1'b0;
    logic i_receive_success_flag = 1'b0, i_transmit_success_flag = 1'b0, i_rx_pin;
    logic [`CBT_BRP_W-1:0] i_prescale = 6'h01;
    logic [`CBT_SEG_W-1:0] i_prop_tq = 4'h1, i_ph1_tq = 4'h3, i_ph2_tq = 4'h3;
    logic [`CBT_SJW_W-1:0] i_sjw_tq = 2'h1;
    logic [7:0] i_timer_prescale = 8'h00;
    logic [`CBT_OBJ_W-1:0] i_obj_index = 4'h0, i_stamp_sel = 4'h0;
    logic o_tx_pin, o_sample_strobe, o_sample_bit, o_bit_start, o_ipt_busy;
    logic o_retransmit_allowed, o_timer_irq;
    logic [7:0] o_stamp_timer_high, o_stamp_timer_low, o_trigger_capture_high;
    logic [7:0] o_trigger_capture_low, o_object_stamp_high, o_object_stamp_low;
    int miscompares = 0, samples_checked = 0;
    int n;
    int m;
    logic peer_pull_low = 1'b0;
    cbt_stamp_t snap, prev, cnt;
    assign cnt = {o_stamp_timer_high, o_stamp_timer_low};
    always #12.5 i_clk_sys = ~i_clk_sys;
    cbt_top dut_u (.*);
    cbt_peer peer_u (.i_tx_pin(o_tx_pin), .i_drive_low(peer_pull_low), .o_bus(i_rx_pin));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk_sys);
    endtask : cyc
    // snap holds the count the design sees at the capturing edge
    // one idle cycle first, so back-to-back pulses never retouch a strobe in one step
    task automatic pulse(ref logic s);
        @(negedge i_clk_sys);
        snap = cnt;
        s = 1'b1;
        @(negedge i_clk_sys);
        s = 1'b0;
    endtask : pulse
    task automatic wait_sig(ref logic s, output int k);
        k = 0;
        do begin
            @(negedge i_clk_sys);
            k++;
        end while (s !== 1'b1 && k < 200);
    endtask : wait_sig
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #(25 * 90000);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        cyc(12);
        i_sys_rst = 1'b0;
        check({o_tx_pin, o_sample_bit, o_retransmit_allowed, o_timer_irq}, 16'he);
        cyc(10);
        check(cnt, 16'h0000);
        i_controller_enable_bit = 1'b1;
        // the timer divider needs one cycle before its first tick
        cyc(2);
        snap = cnt;
        cyc(5);
        check(cnt, snap + 16'h5);
        i_timer_prescale = 8'h01;
        snap = cnt;
        cyc(10);
        check(cnt, snap + 16'h5);
        i_timer_prescale = 8'h00;
        i_time_triggered_mode_bit = 1'b1;
        pulse(i_sof);
        check({o_trigger_capture_high, o_trigger_capture_low}, snap);
        i_trigger_capture_edge_select = 1'b1;
        prev = snap;
        pulse(i_sof);
        check({o_trigger_capture_high, o_trigger_capture_low}, prev);
        pulse(i_eof);
        check({o_trigger_capture_high, o_trigger_capture_low}, snap);
        prev = snap;
        pulse(i_tx_error);
        check(o_retransmit_allowed, 1'b0);
        i_time_triggered_mode_bit = 1'b0;
        pulse(i_eof);
        check({o_trigger_capture_high, o_trigger_capture_low}, prev);
        pulse(i_tx_error);
        check(o_retransmit_allowed, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_obj_index = (i < 2) ? 4'h0 : 4'he;
            i_stamp_sel = i_obj_index;
            if (i[0]) begin
                pulse(i_transmit_success_flag);
            end else begin
                pulse(i_receive_success_flag);
            end
            cyc(1);
            check({o_object_stamp_high, o_object_stamp_low}, snap);
        end
        // index fifteen is out of range, so object fourteen keeps its stamp
        i_obj_index = 4'hf;
        prev = snap;
        pulse(i_receive_success_flag);
        cyc(1);
        check({o_object_stamp_high, o_object_stamp_low}, prev);
        i_tx_active = 1'b1;
        for (int p = 3; p < 6; p += 2) begin
            i_ph1_tq = 4'(p);
            wait_sig(o_bit_start, n);
            wait_sig(o_bit_start, n);
            // n carries the cycles already spent in the current bit
            n = 0;
            for (int b = 0; b < 4; b++) begin
                i_tx_bit = b[0];
                wait_sig(o_bit_start, m);
                check(16'(n + m), 16'(2 * (p + 5)));
                check(o_tx_pin, b[0]);
                wait_sig(o_sample_strobe, n);
                check(16'(n), 16'(2 * (p + 2)));
                cyc(1);
                n++;
                check(o_sample_bit, b[0]);
                check(o_ipt_busy, 1'b1);
            end
        end
        i_tx_active = 1'b0;
        // listening only: an edge in phase one stretches it by one sjw
        wait_sig(o_bit_start, n);
        peer_pull_low = 1'b1;
        wait_sig(o_bit_start, n);
        check(16'(n), 16'h16);
        peer_pull_low = 1'b0;
        cyc(10);
        // an edge in phase two cuts it down to the two-quantum floor
        peer_pull_low = 1'b1;
        wait_sig(o_bit_start, n);
        check(16'(n + 10), 16'h12);
        peer_pull_low = 1'b0;
        i_timer_wrap_irq_enable = 1'b1;
        n = 0;
        while (cnt !== 16'hffff && n < 70000) begin
            cyc(1);
            n++;
        end
        cyc(1);
        check(cnt, 16'h0000);
        n = 0;
        repeat (3) begin
            cyc(1);
            n = n | int'(o_timer_irq === 1'b1);
        end
        check(16'(n), 16'h1);
        tally_and_finish();
    end
endmodule : tb_top
